// [core/usb2_afe_test_pkg.sv]
// Constants for the front-end test register: offsets, field positions, reset values
package usb2_afe_test_pkg;
  // Register port geometry
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam logic [7:0] USB2_FRONTEND_TEST_OFFSET = 8'hc4;
  // Field positions
  localparam int FS_OE_N_BIT = 22;
  localparam int FS_POS_BIT = 21;
  localparam int FS_NEG_BIT = 20;
  localparam int FS_RX_BIT = 19;
  localparam int HS_MASK_LO = 14;
  localparam int HS_DATA_LO = 12;
  localparam int HS_CS_BIT = 11;
  localparam int TRIM_LO = 8;
  localparam int PU_DP_BIT = 7;
  localparam int PU_DM_BIT = 6;
  localparam int PD_DP_BIT = 5;
  localparam int PD_DM_BIT = 4;
  localparam int HS_ACT_BIT = 1;
  // Reserved bits 31:23, 18:16, 3:2, 0 read as zero
  localparam logic [31:0] RESERVED_MASK = 32'hff87_000d;
  // Reset values and encodings
  localparam logic RST_BIT = 1'h0;
  localparam logic [1:0] RST_MASK = 2'h0;
  localparam logic [1:0] RST_DATA = 2'h0;
  localparam logic [2:0] TRIM_NOMINAL = 3'h0;
  localparam logic [1:0] MASK_NONE = 2'h0;
  localparam logic [1:0] MASK_LSB = 2'h1;
  localparam logic [1:0] MASK_BAD = 2'h2;
  localparam logic [1:0] MASK_BOTH = 2'h3;
  localparam logic [31:0] READ_IDLE = 32'h0000_0000;
endpackage

// [core/level_sync2.sv]
// Two-flop synchroniser for levels arriving from outside the clock domain
`timescale 1ns/1ps
module level_sync2 #(
  parameter int WIDTH = 1
) (
  input wire logic clk_in, // System clock
  input wire logic rst_in, // Async reset, active high
  input wire logic [WIDTH-1:0] async_in, // Unsynchronised level
  output logic [WIDTH-1:0] sync_out // Synchronised level
);
  logic [WIDTH-1:0] stage1;

  initial
  begin
    if (WIDTH < 1) $error("level_sync2: WIDTH must be at least 1");
  end

  // First stage feeds only the second stage
  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      stage1 <= '0;
      sync_out <= '0;
    end
    else
    begin
      stage1 <= async_in;
      sync_out <= stage1;
    end
  end
endmodule // level_sync2

// [core/hs_bit_serialiser.sv]
// Shifts the high-speed transmit bits onto the line, least significant first
`timescale 1ns/1ps
module hs_bit_serialiser #(
  parameter int WIDTH = 2
) (
  input wire logic clk_in, // System clock
  input wire logic rst_in, // Async reset, active high
  input wire logic load_in, // Pulse: take new bits
  input wire logic [WIDTH-1:0] data_in, // Bits to send
  input wire logic [1:0] count_in, // Number of valid bits
  output logic bit_out, // Serial bit
  output logic valid_out // Serial bit is valid
);
  logic [WIDTH-1:0] shift;
  logic [1:0] left;

  initial
  begin
    if (WIDTH != 2) $error("hs_bit_serialiser: WIDTH must be 2");
  end

  // A new load with a nonzero count restarts the sequence; unsent bits are dropped
  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      shift <= '0;
      left <= 2'h0;
      bit_out <= 1'h0;
      valid_out <= 1'h0;
    end
    else if (load_in && count_in != 2'h0)
    begin
      bit_out <= data_in[0]; // [R05]
      valid_out <= 1'h1;
      shift <= {1'h0, data_in[WIDTH-1:1]};
      left <= 2'(count_in - 2'h1);
    end
    else if (left != 2'h0)
    begin
      bit_out <= shift[0]; // [R05]
      valid_out <= 1'h1;
      shift <= {1'h0, shift[WIDTH-1:1]};
      left <= 2'(left - 2'h1);
    end
    else
    begin
      valid_out <= 1'h0;
      bit_out <= 1'h0;
    end
  end

  // Two bits leave low bit first, on consecutive cycles
  property p_lsb_first;
    @(posedge clk_in) disable iff (rst_in)
    (load_in && count_in == 2'h2)
      |=> (bit_out == $past(data_in[0]) && valid_out)
      ##1 (bit_out == $past(data_in[1], 2) && valid_out);
  endproperty
  a_lsb_first: assert property (p_lsb_first) else $error("HS bits not LSB first"); // [R05]
endmodule // hs_bit_serialiser

// [core/usb2_afe_test_register.sv]
// Software test register giving direct control of the USB 2.0 analog front end
// Behaviour
// [R01] Driver enable is active low: 0 drives the FS/LS line, 1 leaves the outputs floating.
// [R02] Two writable bits set the FS/LS levels, one for DP and one for DM.
// [R03] A read-only bit shows the FS/LS differential receiver; writes to it do nothing.
// [R04] The HS valid mask is 00 none, 01 low bit, 11 both; 10 is illegal and is refused.
// [R05] The two HS transmit bits go onto the line low bit first.
// [R06] Current source enable powers the driver; it is forced on while in HS mode.
// [R07] A three-bit trim sets HS drive current: nominal, minus 5 or plus 5 to 30 percent.
// [R08] Under reset protection, USB and lite resets leave the trim untouched.
// [R09] Trim defaults from the EEPROM flag, else the OTP value, else 000.
// [R10] USB or lite reset reloads the trim from the last EEPROM image, or 000 without EEPROM.
// [R11] Bit 7 switches the DP pull-up and bit 6 the DM pull-up.
// [R12] Bit 5 switches the DP pull-down and bit 4 the DM pull-down.
// [R13] Driver active 0 is low-power idle, 1 is active transmit with source on.
// [R14] Reserved bits read zero and ignore writes; other fields but the trim reset to zero.
`timescale 1ns/1ps
module usb2_afe_test_register
  import usb2_afe_test_pkg::*;
(
  input wire logic clk_in, // 50 MHz system clock
  input wire logic rst_in, // Async reset, active high
  input wire logic [ADDR_W-1:0] addr_in, // Register address
  input wire logic [DATA_W-1:0] wdata_in, // Write data
  input wire logic wr_in, // Write strobe
  input wire logic rd_in, // Read strobe
  output logic [DATA_W-1:0] rdata_out, // Read data, cycle after strobe
  input wire logic fs_diff_receiver_in, // FS receiver pin, async
  input wire logic hs_mode_in, // Port runs high speed
  input wire logic usb_reset_in, // USB reset pulse
  input wire logic lite_reset_in, // Lite reset pulse
  input wire logic reset_protect_in, // Reset protection in force
  input wire logic eeprom_present_in, // EEPROM image loaded
  input wire logic [2:0] image_drive_current_flag_in, // Trim from EEPROM image
  input wire logic otp_programmed_in, // OTP holds a trim
  input wire logic [2:0] otp_trim_in, // Trim from OTP
  output logic fs_driver_out_enable_n_out, // FS driver enable, low active
  output logic fs_positive_out_level_out, // FS level on DP
  output logic fs_negative_out_level_out, // FS level on DM
  output logic [1:0] frontend_hs_valid_bus_out, // HS valid mask
  output logic hs_serial_bit_out, // HS serial data
  output logic hs_serial_valid_out, // HS serial data valid
  output logic hs_current_source_on_out, // HS current source
  output logic [2:0] hs_drive_current_trim_out, // HS current trim
  output logic pullup_dp_on_out, // 1.5k pull-up on DP
  output logic pullup_dm_on_out, // 1.5k pull-up on DM
  output logic pulldown_dp_on_out, // 15k pull-down on DP
  output logic pulldown_dm_on_out, // 15k pull-down on DM
  output logic hs_driver_active_out // HS driver active
);

  // Register fields
  logic fs_driver_out_enable_n;
  logic fs_positive_out_level;
  logic fs_negative_out_level;
  logic [1:0] hs_tx_valid_mask;
  logic [1:0] hs_tx_bits;
  logic hs_current_source_on;
  logic [2:0] hs_drive_current_trim;
  logic pullup_dp_on;
  logic pullup_dm_on;
  logic pulldown_dp_on;
  logic pulldown_dm_on;
  logic hs_driver_active;
  // Trim image and power-up bookkeeping
  logic [2:0] image_trim;
  logic image_valid;
  logic init_pending;
  logic fs_rx_sync;
  logic wr_hit;
  logic rd_hit;
  logic link_reset;
  logic [1:0] serial_count;
  logic [DATA_W-1:0] read_value;

  // Address decode shared by reads and writes
  function automatic logic reg_hit(input logic [ADDR_W-1:0] addr);
    reg_hit = (addr == USB2_FRONTEND_TEST_OFFSET);
  endfunction

  assign wr_hit = wr_in && reg_hit(addr_in);
  assign rd_hit = rd_in && reg_hit(addr_in);
  assign link_reset = usb_reset_in || lite_reset_in;

  // Receiver pin crosses into the clock domain before anyone reads it
  level_sync2 #(
    .WIDTH(1)
  ) u_rx_sync (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .async_in(fs_diff_receiver_in),
    .sync_out(fs_rx_sync)
  );

  // FS/LS driver override fields
  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      fs_driver_out_enable_n <= RST_BIT; // [R14]
      fs_positive_out_level <= RST_BIT;
      fs_negative_out_level <= RST_BIT;
    end
    else if (wr_hit)
    begin
      fs_driver_out_enable_n <= wdata_in[FS_OE_N_BIT]; // [R01]
      fs_positive_out_level <= wdata_in[FS_POS_BIT]; // [R02]
      fs_negative_out_level <= wdata_in[FS_NEG_BIT]; // [R02]
    end
  end

  // HS transmit fields; an illegal mask write leaves the old mask
  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      hs_tx_valid_mask <= RST_MASK; // [R14]
      hs_tx_bits <= RST_DATA;
      hs_current_source_on <= RST_BIT;
      hs_driver_active <= RST_BIT;
    end
    else if (wr_hit)
    begin
      if (wdata_in[HS_MASK_LO +: 2] != MASK_BAD)
      begin
        hs_tx_valid_mask <= wdata_in[HS_MASK_LO +: 2]; // [R04]
      end
      hs_tx_bits <= wdata_in[HS_DATA_LO +: 2];
      hs_current_source_on <= wdata_in[HS_CS_BIT]; // [R06]
      hs_driver_active <= wdata_in[HS_ACT_BIT]; // [R13]
    end
  end

  // Termination fields; bit 6 taken as the DM pull-up
  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      pullup_dp_on <= RST_BIT; // [R14]
      pullup_dm_on <= RST_BIT;
      pulldown_dp_on <= RST_BIT;
      pulldown_dm_on <= RST_BIT;
    end
    else if (wr_hit)
    begin
      pullup_dp_on <= wdata_in[PU_DP_BIT]; // [R11]
      pullup_dm_on <= wdata_in[PU_DM_BIT]; // [R11]
      pulldown_dp_on <= wdata_in[PD_DP_BIT]; // [R12]
      pulldown_dm_on <= wdata_in[PD_DM_BIT]; // [R12]
    end
  end

  // Power-up marker: straps are sampled on the first edge after release
  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      init_pending <= 1'h1;
    end
    else
    begin
      init_pending <= 1'h0;
    end
  end

  // Remember the EEPROM image so a link reset can restore it
  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      image_trim <= TRIM_NOMINAL;
      image_valid <= 1'h0;
    end
    else if (init_pending)
    begin
      image_valid <= eeprom_present_in;
      image_trim <= eeprom_present_in ? image_drive_current_flag_in : TRIM_NOMINAL;
    end
  end

  // Current trim: default load, link-reset reload, then software writes.
  // A link reset without reset protection wins over a write in the same cycle.
  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      hs_drive_current_trim <= TRIM_NOMINAL;
    end
    else if (init_pending)
    begin
      if (eeprom_present_in)
      begin
        hs_drive_current_trim <= image_drive_current_flag_in; // [R09]
      end
      else if (otp_programmed_in)
      begin
        hs_drive_current_trim <= otp_trim_in; // [R09]
      end
      else
      begin
        hs_drive_current_trim <= TRIM_NOMINAL; // [R09]
      end
    end
    else if (link_reset && !reset_protect_in) // [R08]
    begin
      hs_drive_current_trim <= image_valid ? image_trim : TRIM_NOMINAL; // [R10]
    end
    else if (wr_hit)
    begin
      hs_drive_current_trim <= wdata_in[TRIM_LO +: 3]; // [R07]
    end
  end

  // Number of serial bits from the mask
  always_comb
  begin
    case (hs_tx_valid_mask)
      MASK_LSB: serial_count = 2'h1;
      MASK_BOTH: serial_count = 2'h2;
      default: serial_count = 2'h0;
    endcase
  end

  // Bits are loaded only while the driver is active; a loaded pair still finishes
  hs_bit_serialiser #(
    .WIDTH(2)
  ) u_serialiser (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .load_in(hs_driver_active && !hs_serial_valid_out),
    .data_in(hs_tx_bits),
    .count_in(serial_count),
    .bit_out(hs_serial_bit_out),
    .valid_out(hs_serial_valid_out)
  );

  // Outputs to the front end, each from its own flop
  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      fs_driver_out_enable_n_out <= RST_BIT;
      fs_positive_out_level_out <= RST_BIT;
      fs_negative_out_level_out <= RST_BIT;
      frontend_hs_valid_bus_out <= RST_MASK;
      hs_current_source_on_out <= RST_BIT;
      hs_drive_current_trim_out <= TRIM_NOMINAL;
      pullup_dp_on_out <= RST_BIT;
      pullup_dm_on_out <= RST_BIT;
      pulldown_dp_on_out <= RST_BIT;
      pulldown_dm_on_out <= RST_BIT;
      hs_driver_active_out <= RST_BIT;
    end
    else
    begin
      fs_driver_out_enable_n_out <= fs_driver_out_enable_n; // [R01]
      fs_positive_out_level_out <= fs_positive_out_level; // [R02]
      fs_negative_out_level_out <= fs_negative_out_level; // [R02]
      frontend_hs_valid_bus_out <= hs_tx_valid_mask; // [R04]
      // Active transmit needs the source up, as does HS mode
      hs_current_source_on_out <= hs_current_source_on || hs_mode_in
        || hs_driver_active; // [R06] [R13]
      hs_drive_current_trim_out <= hs_drive_current_trim; // [R07]
      pullup_dp_on_out <= pullup_dp_on; // [R11]
      pullup_dm_on_out <= pullup_dm_on; // [R11]
      pulldown_dp_on_out <= pulldown_dp_on; // [R12]
      pulldown_dm_on_out <= pulldown_dm_on; // [R12]
      hs_driver_active_out <= hs_driver_active; // [R13]
    end
  end

  // Read image; reserved positions stay zero
  always_comb
  begin
    read_value = READ_IDLE; // [R14]
    read_value[FS_OE_N_BIT] = fs_driver_out_enable_n;
    read_value[FS_POS_BIT] = fs_positive_out_level;
    read_value[FS_NEG_BIT] = fs_negative_out_level;
    read_value[FS_RX_BIT] = fs_rx_sync; // [R03]
    read_value[HS_MASK_LO +: 2] = hs_tx_valid_mask;
    read_value[HS_DATA_LO +: 2] = hs_tx_bits;
    read_value[HS_CS_BIT] = hs_current_source_on;
    read_value[TRIM_LO +: 3] = hs_drive_current_trim;
    read_value[PU_DP_BIT] = pullup_dp_on;
    read_value[PU_DM_BIT] = pullup_dm_on;
    read_value[PD_DP_BIT] = pulldown_dp_on;
    read_value[PD_DM_BIT] = pulldown_dm_on;
    read_value[HS_ACT_BIT] = hs_driver_active;
  end

  // Read data stand one cycle only; unmapped reads return zero
  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      rdata_out <= READ_IDLE;
    end
    else
    begin
      rdata_out <= rd_hit ? read_value : READ_IDLE;
    end
  end

  // Enable bit reaches the pin two cycles after the write
  property p_oe_low_active;
    @(posedge clk_in) disable iff (rst_in)
    wr_hit |-> ##2 (fs_driver_out_enable_n_out == $past(wdata_in[FS_OE_N_BIT], 2));
  endproperty
  a_oe_low_active: assert property (p_oe_low_active) else $error("FS enable wrong"); // [R01]

  property p_fs_levels;
    @(posedge clk_in) disable iff (rst_in)
    wr_hit |-> ##2 (fs_positive_out_level_out == $past(wdata_in[FS_POS_BIT], 2)
      && fs_negative_out_level_out == $past(wdata_in[FS_NEG_BIT], 2));
  endproperty
  a_fs_levels: assert property (p_fs_levels) else $error("FS levels wrong"); // [R02]

  property p_rx_readback;
    @(posedge clk_in) disable iff (rst_in)
    rd_hit |=> (rdata_out[FS_RX_BIT] == $past(fs_rx_sync));
  endproperty
  a_rx_readback: assert property (p_rx_readback) else $error("Receiver readback wrong"); // [R03]

  property p_mask_refused;
    @(posedge clk_in) disable iff (rst_in)
    (wr_hit && wdata_in[HS_MASK_LO +: 2] == MASK_BAD) |=> $stable(hs_tx_valid_mask);
  endproperty
  a_mask_refused: assert property (p_mask_refused) else $error("Illegal mask taken"); // [R04]

  property p_hs_source;
    @(posedge clk_in) disable iff (rst_in)
    hs_mode_in |=> hs_current_source_on_out;
  endproperty
  a_hs_source: assert property (p_hs_source) else $error("Source off in HS mode"); // [R06]

  property p_trim_write;
    @(posedge clk_in) disable iff (rst_in)
    (wr_hit && !link_reset && !init_pending)
      |-> ##2 (hs_drive_current_trim_out == $past(wdata_in[TRIM_LO +: 3], 2));
  endproperty
  a_trim_write: assert property (p_trim_write) else $error("Trim write lost"); // [R07]

  property p_trim_protected;
    @(posedge clk_in) disable iff (rst_in)
    (link_reset && reset_protect_in && !wr_hit && !init_pending)
      |=> $stable(hs_drive_current_trim);
  endproperty
  a_trim_protected: assert property (p_trim_protected) else $error("Protected trim changed"); // [R08]

  property p_trim_default;
    @(posedge clk_in) disable iff (rst_in)
    (init_pending && !eeprom_present_in && !otp_programmed_in)
      |=> (hs_drive_current_trim == TRIM_NOMINAL);
  endproperty
  a_trim_default: assert property (p_trim_default) else $error("Trim default wrong"); // [R09]

  property p_trim_reload;
    @(posedge clk_in) disable iff (rst_in)
    (link_reset && !reset_protect_in && !init_pending)
      |=> (hs_drive_current_trim == (image_valid ? image_trim : TRIM_NOMINAL));
  endproperty
  a_trim_reload: assert property (p_trim_reload) else $error("Trim reload wrong"); // [R10]

  property p_pullups;
    @(posedge clk_in) disable iff (rst_in)
    wr_hit |-> ##2 (pullup_dp_on_out == $past(wdata_in[PU_DP_BIT], 2)
      && pullup_dm_on_out == $past(wdata_in[PU_DM_BIT], 2));
  endproperty
  a_pullups: assert property (p_pullups) else $error("Pull-up wrong"); // [R11]

  property p_pulldowns;
    @(posedge clk_in) disable iff (rst_in)
    wr_hit |-> ##2 (pulldown_dp_on_out == $past(wdata_in[PD_DP_BIT], 2)
      && pulldown_dm_on_out == $past(wdata_in[PD_DM_BIT], 2));
  endproperty
  a_pulldowns: assert property (p_pulldowns) else $error("Pull-down wrong"); // [R12]

  property p_active_source;
    @(posedge clk_in) disable iff (rst_in)
    hs_driver_active |=> (hs_driver_active_out && hs_current_source_on_out);
  endproperty
  a_active_source: assert property (p_active_source) else $error("Active without source"); // [R13]

  property p_reserved_zero;
    @(posedge clk_in) disable iff (rst_in)
    rd_in |=> ((rdata_out & RESERVED_MASK) == READ_IDLE);
  endproperty
  a_reserved_zero: assert property (p_reserved_zero) else $error("Reserved bits set"); // [R14]
endmodule // usb2_afe_test_register

// [test/usb2_afe_model.sv]
// Behavioural analog front end: what the full-speed receiver sees on the line
`timescale 1ns/1ps
module usb2_afe_model (
  input wire logic clk_in, // System clock
  input wire logic drive_n_in, // FS driver enable, low active
  input wire logic dp_level_in, // Level driven onto DP
  input wire logic dm_level_in, // Level driven onto DM
  input wire logic pullup_dp_in, // DP pull-up switched on
  input wire logic pulldown_dp_in, // DP pull-down switched on
  output logic receiver_out // Differential receiver output
);
  // Receiver follows the driven pair, else the terminations; a floating line wanders
  always @(posedge clk_in)
  begin
    if (!drive_n_in)
      receiver_out <= dp_level_in & !dm_level_in;
    else if (pullup_dp_in)
      receiver_out <= 1'h1;
    else if (pulldown_dp_in)
      receiver_out <= 1'h0;
    else
      receiver_out <= !receiver_out; // No stale level on a released line
  end
endmodule // usb2_afe_model

// [test/usb2_afe_test_register_test.sv]
// Self-checking bench for the front-end test register
`timescale 1ns/1ps
module usb2_afe_test_register_test;
  import usb2_afe_test_pkg::*;
  localparam logic [7:0] REG = USB2_FRONTEND_TEST_OFFSET;
  logic clk_in = 1'h0;
  logic rst_in = 1'h1;
  logic [7:0] addr_in = 8'h00;
  logic [31:0] wdata_in = 32'h0;
  logic wr_in = 1'h0, rd_in = 1'h0, hs_mode_in = 1'h0;
  logic usb_reset_in = 1'h0, lite_reset_in = 1'h0, reset_protect_in = 1'h0;
  logic eeprom_present_in = 1'h0, otp_programmed_in = 1'h0;
  logic [2:0] flag_in = 3'h0, otp_trim_in = 3'h0;
  logic [31:0] rdata_out;
  logic rx, en_n, pos, neg, ser_bit, ser_valid, cs, pu_dp, pu_dm, pd_dp, pd_dm, act;
  logic [1:0] valid_bus;
  logic [2:0] trim;
  int mismatches = 0;
  int tests_run = 0;
  int cycles = 0;
  int fb[8] = '{22, 21, 20, 11, 7, 6, 5, 4};
  int pb[8] = '{13, 12, 11, 8, 4, 3, 2, 1};

  usb2_afe_test_register i_usb2_afe_test_register (.clk_in(clk_in), .rst_in(rst_in),
    .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
    .rdata_out(rdata_out), .fs_diff_receiver_in(rx), .hs_mode_in(hs_mode_in),
    .usb_reset_in(usb_reset_in), .lite_reset_in(lite_reset_in),
    .reset_protect_in(reset_protect_in), .eeprom_present_in(eeprom_present_in),
    .image_drive_current_flag_in(flag_in), .otp_programmed_in(otp_programmed_in),
    .otp_trim_in(otp_trim_in), .fs_driver_out_enable_n_out(en_n),
    .fs_positive_out_level_out(pos), .fs_negative_out_level_out(neg),
    .frontend_hs_valid_bus_out(valid_bus), .hs_serial_bit_out(ser_bit),
    .hs_serial_valid_out(ser_valid), .hs_current_source_on_out(cs),
    .hs_drive_current_trim_out(trim), .pullup_dp_on_out(pu_dp), .pullup_dm_on_out(pu_dm),
    .pulldown_dp_on_out(pd_dp), .pulldown_dm_on_out(pd_dm), .hs_driver_active_out(act));

  usb2_afe_model i_usb2_afe_model (.clk_in(clk_in), .drive_n_in(en_n), .dp_level_in(pos),
    .dm_level_in(neg), .pullup_dp_in(pu_dp), .pulldown_dp_in(pd_dp), .receiver_out(rx));

  // Clock and hang guard; the whole run needs well under a thousand cycles
  always #10 clk_in = ~clk_in;
  always @(posedge clk_in)
  begin
    cycles <= cycles + 1;
    if (cycles == 5000)
    begin
      mismatches++;
      results();
    end
  end

  function automatic logic [31:0] pins();
    return {18'h0, en_n, pos, neg, valid_bus, cs, trim, pu_dp, pu_dm, pd_dp, pd_dm, act};
  endfunction

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      mismatches++;
      $display("unexpected at %0t ns: got %h expected %h", $time, got, exp);
    end
  endtask

  // Bus cycles: one-cycle strobes launched right after an edge
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_in);
    addr_in <= a;
    wdata_in <= d;
    wr_in <= 1'h1;
    @(posedge clk_in);
    wr_in <= 1'h0;
  endtask

  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
    @(posedge clk_in);
    addr_in <= a;
    rd_in <= 1'h1;
    @(posedge clk_in);
    rd_in <= 1'h0;
    #1 check(rdata_out, exp);
  endtask

  task automatic power_up(input logic ee, input logic op, input logic [2:0] ot);
    @(posedge clk_in);
    eeprom_present_in <= ee;
    flag_in <= 3'h5;
    otp_programmed_in <= op;
    otp_trim_in <= ot;
    rst_in <= 1'h1;
    repeat (20) @(posedge clk_in);
    rst_in <= 1'h0;
    repeat (2) @(posedge clk_in);
  endtask

  task automatic link_reset(input logic lite);
    @(posedge clk_in);
    usb_reset_in <= !lite;
    lite_reset_in <= lite;
    @(posedge clk_in);
    usb_reset_in <= 1'h0;
    lite_reset_in <= 1'h0;
  endtask

  // Counts serial bits after a write, keeping the first four; it does not flush an older word
  task automatic collect(input logic [3:0] exp, input int cnt);
    logic [3:0] got;
    int n;
    got = 4'h0;
    n = 0;
    repeat (16)
    begin
      @(posedge clk_in);
      #1;
      if (ser_valid === 1'h1 && n < 4)
      begin
        got[n] = ser_bit;
        n++;
      end
    end
    check({28'h0, got}, {28'h0, exp});
    check(32'(n), 32'(cnt));
  endtask

  task automatic t_defaults();
    power_up(1'h1, 1'h1, 3'h6);
    #1 check(pins(), 32'h0000_00a0);
    power_up(1'h0, 1'h1, 3'h6);
    rdchk(REG, 32'h0000_0600);
    link_reset(1'h0);
    rdchk(REG, 32'h0000_0000);
    power_up(1'h0, 1'h0, 3'h6);
    rdchk(REG, 32'h0000_0000);
    power_up(1'h1, 1'h1, 3'h6);
    rdchk(REG, 32'h0000_0500);
  endtask

  task automatic t_fields();
    wr(8'hc0, 32'hffff_ffff);
    rdchk(8'hc0, 32'h0);
    rdchk(REG, 32'h0000_0500);
    wr(REG, 32'hffff_ffff);
    repeat (6) @(posedge clk_in);
    #1 check(pins(), 32'h0000_3fff);
    rdchk(REG, 32'h0078_fff2);
    wr(REG, 32'h0000_8000);
    // Receiver bit trails the driver pins by the model and the synchroniser
    repeat (4) @(posedge clk_in);
    #1 check(pins(), 32'h0000_0600);
    rdchk(REG, 32'h0000_c000);
    wr(REG, 32'h0);
    foreach (fb[i])
    begin
      wr(REG, 32'h1 << fb[i]);
      @(posedge clk_in);
      #1 check(pins(), 32'h1 << pb[i]);
    end
  endtask

  task automatic t_receiver();
    wr(REG, 32'h0020_0000);
    repeat (6) @(posedge clk_in);
    rdchk(REG, 32'h0028_0000);
    wr(REG, 32'h0048_0080);
    repeat (6) @(posedge clk_in);
    rdchk(REG, 32'h0048_0080);
    wr(REG, 32'h0008_0000);
    repeat (6) @(posedge clk_in);
    rdchk(REG, 32'h0);
  endtask

  task automatic t_trim();
    for (int i = 0; i < 8; i++)
    begin
      wr(REG, 32'(i) << TRIM_LO);
      @(posedge clk_in);
      #1 check({29'h0, trim}, 32'(i));
    end
    wr(REG, 32'h0000_0300);
    reset_protect_in <= 1'h1;
    link_reset(1'h0);
    rdchk(REG, 32'h0000_0300);
    @(posedge clk_in);
    reset_protect_in <= 1'h0;
    link_reset(1'h1);
    rdchk(REG, 32'h0000_0500);
    wr(REG, 32'h0000_0200);
    link_reset(1'h0);
    repeat (2) @(posedge clk_in);
    #1 check({29'h0, trim}, 32'h5);
  endtask

  task automatic t_serial();
    wr(REG, 32'h0000_e002);
    collect(4'ha, 4);
    check({31'h0, cs}, 32'h1);
    wr(REG, 32'h0);
    repeat (4) @(posedge clk_in);
    wr(REG, 32'h0000_5002);
    collect(4'hf, 4);
    wr(REG, 32'h0);
    repeat (4) @(posedge clk_in);
    wr(REG, 32'h0000_3002);
    collect(4'h0, 0);
    wr(REG, 32'h0);
  endtask

  task automatic t_hs_mode();
    @(posedge clk_in);
    hs_mode_in <= 1'h1;
    repeat (3) @(posedge clk_in);
    #1 check({31'h0, cs}, 32'h1);
    @(posedge clk_in);
    hs_mode_in <= 1'h0;
    repeat (3) @(posedge clk_in);
    #1 check({31'h0, cs}, 32'h0);
  endtask

  // Single place where the run ends
  task automatic results();
    $display("mismatches %0d tests_run %0d", mismatches, tests_run);
    if (mismatches == 0 && tests_run > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  // Main sequence
  initial
  begin
    t_defaults();
    t_fields();
    t_receiver();
    t_trim();
    t_serial();
    t_hs_mode();
    results();
  end
endmodule // usb2_afe_test_register_test
